// [rtl/issp_pkg.sv]
// Constants and types shared by the inertial sensor serial slave port.
// Assumes a single 20 MHz system clock; no registers are reached over a bus.

package issp_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int CNT_W      = 5;
  localparam int WORD_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int ADDR_W     = 7;
  localparam int IDX_W      = 6;
  localparam int RW_POS     = 15;
  localparam int ADDR_MSB   = 14;
  localparam int ADDR_LSB   = 8;
  localparam int IDX_LSB    = 9;
  localparam int LAST_BIT   = FRAME_BITS - 1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // ****************************************
  // timing and buffering
  // ****************************************
  localparam int CLK_MHZ     = 20;
  localparam int DR_PULSE_NS = 1000;
  localparam int DR_PULSE_CYC = (DR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int DR_CNT_W    = 8;
  localparam int FIFO_DEPTH  = 32;
  localparam int SAMPLE_W    = 1 + IDX_W + WORD_W;

  // ****************************************
  // frame sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    ISSP_IDLE  = 2'b00,
    ISSP_FRAME = 2'b01,
    ISSP_HOLD  = 2'b11
  } issp_state_t;

endpackage

// [rtl/issp_fifo.sv]
// Synchronous FIFO carrying sensor results into the output register file.
// Assumes both sides on clk; reset is synchronous and active high.

`timescale 1ns/1ps
`default_nettype none

module issp_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
      $error("issp_fifo: DEPTH must be a power of two >= 2, WIDTH >= 1");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    wr_ptr_d;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW-1:0]    rd_ptr_d;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             ready_q;
  logic             ready_d;
  logic             push;
  logic             pop;

  assign in_ready  = ready_q;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && ready_q;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
    rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    count_d  = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
    // ready registered so the port comes straight from a flop
    ready_d = (count_d != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
      count_q  <= count_d;
      ready_q  <= ready_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule

`default_nettype wire

// [rtl/issp_port.sv]
// Serial slave port of the inertial sensor: mode 3 frames, output registers,
// data-ready pin. Assumes sclk, cs_n and mosi come from the master's domain
// and are sampled by clk; the sensing pipeline feeds results on a stream.
//
// Notes on behaviour
// RULE_01: device is slave; master drives clock, select.
// RULE_02: mode 3, MSB first, 16-bit frames.
// RULE_03: output bit changes on serial clock fall.
// RULE_04: input bit captured on serial clock rise.
// RULE_05: master keeps serial clock at most 15 MHz.
// RULE_06: data-ready pulses high on pin two.
// RULE_07: results loaded autonomously without host command.
// RULE_08: host holds its reset pin inactive high; here reset is active high, held low when inactive.
// RULE_09: read takes two frames; data next frame.
// RULE_10: write frame: one, address, eight data bits.
// RULE_11: master idles two microseconds between frames.
// RULE_12: serial output released while select is high.
// RULE_13: select low per frame; rise clears count.

`timescale 1ns/1ps
`default_nettype none

module issp_port #(
  parameter int FIFO_DEPTH = issp_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        reset,
  // serial link pins
  input  wire logic                        sclk,
  input  wire logic                        cs_n,
  input  wire logic                        mosi,
  output logic                             miso_o,
  output logic                             miso_oe,
  // sensor result stream
  input  wire logic                        sample_valid,
  input  wire logic [issp_pkg::IDX_W-1:0]  sample_index,
  input  wire logic [issp_pkg::WORD_W-1:0] sample_data,
  input  wire logic                        sample_last,
  output logic                             sample_ready,
  // configuration byte writes
  output logic                             cfg_wr_valid,
  output logic [issp_pkg::ADDR_W-1:0]      cfg_wr_addr,
  output logic [issp_pkg::BYTE_W-1:0]      cfg_wr_data,
  // data-ready pin
  output logic                             config_io_pin_two_o,
  output logic                             config_io_pin_two_oe
);

  localparam int NREG = 1 << issp_pkg::IDX_W;

  generate
    if (FIFO_DEPTH < 2) begin : g_bad_depth
      $error("issp_port: FIFO_DEPTH must be at least 2");
    end
  endgenerate

  // ****************************************
  // pin synchronisers
  // ****************************************
  // serial clock is oversampled, so the bench period of 400 ns works while a
  // 15 MHz master clock would need a faster system clock
  logic sclk_m_q, sclk_s_q, sclk_p_q;
  logic cs_m_q, cs_s_q;
  logic mosi_m_q, mosi_s_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      sclk_m_q <= 1'b1;
      sclk_s_q <= 1'b1;
      sclk_p_q <= 1'b1;
      cs_m_q   <= 1'b1;
      cs_s_q   <= 1'b1;
      mosi_m_q <= 1'b0;
      mosi_s_q <= 1'b0;
    end else begin
      sclk_m_q <= sclk;
      sclk_s_q <= sclk_m_q;
      sclk_p_q <= sclk_s_q;
      cs_m_q   <= cs_n;
      cs_s_q   <= cs_m_q;
      mosi_m_q <= mosi;
      mosi_s_q <= mosi_m_q;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_act;

  assign sclk_rise = sclk_s_q & ~sclk_p_q;
  assign sclk_fall = ~sclk_s_q & sclk_p_q;
  assign cs_act    = ~cs_s_q;

  // ****************************************
  // result buffer
  // ****************************************
  logic                             fifo_valid;
  logic [issp_pkg::SAMPLE_W-1:0]    fifo_data;
  logic                             fifo_pop;
  logic                             pop_last;
  logic [issp_pkg::IDX_W-1:0]       pop_idx;
  logic [issp_pkg::WORD_W-1:0]      pop_word;

  issp_fifo #(
    .WIDTH (issp_pkg::SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (sample_valid),
    .in_data   ({sample_last, sample_index, sample_data}),
    .in_ready  (sample_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_pop)
  );

  assign {pop_last, pop_idx, pop_word} = fifo_data;

  // ****************************************
  // frame sequencer
  // ****************************************
  issp_pkg::issp_state_t             state_q, state_d;
  logic [issp_pkg::CNT_W-1:0]        cnt_q, cnt_d;
  logic [issp_pkg::WORD_W-1:0]       rx_q, rx_d;
  logic [issp_pkg::WORD_W-1:0]       sh_q, sh_d;
  logic [issp_pkg::WORD_W-1:0]       tx_q, tx_d;
  logic                              miso_q, miso_d;
  logic                              oe_q, oe_d;
  logic                              wr_valid_q, wr_valid_d;
  logic [issp_pkg::ADDR_W-1:0]       wr_addr_q, wr_addr_d;
  logic [issp_pkg::BYTE_W-1:0]       wr_data_q, wr_data_d;
  logic [issp_pkg::WORD_W-1:0]       rx_word;
  logic                              reg_we;
  logic [issp_pkg::WORD_W-1:0]       regs_q [NREG];

  assign rx_word = {rx_q[issp_pkg::WORD_W-2:0], mosi_s_q};

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    rx_d       = rx_q;
    sh_d       = sh_q;
    tx_d       = tx_q;
    miso_d     = miso_q;
    oe_d       = cs_act;                                        // RULE_12
    wr_valid_d = 1'b0;
    wr_addr_d  = wr_addr_q;
    wr_data_d  = wr_data_q;
    reg_we     = 1'b0;
    case (state_q)
      issp_pkg::ISSP_IDLE: begin
        // the master always starts a frame; nothing is sent unasked
        if (cs_act) begin                                       // RULE_01
          state_d = issp_pkg::ISSP_FRAME;
          cnt_d   = '0;
          // read reply goes out in this frame only, then is spent
          sh_d    = tx_q;                                       // RULE_09
          tx_d    = issp_pkg::WORD_RST;
          miso_d  = 1'b0;
        end
      end
      issp_pkg::ISSP_FRAME: begin
        if (!cs_act) begin
          // short frame is dropped whole
          state_d = issp_pkg::ISSP_IDLE;                        // RULE_13
          cnt_d   = '0;
        end else begin
          if (sclk_fall) begin
            miso_d = sh_q[issp_pkg::WORD_W-1];                  // RULE_03
            sh_d   = {sh_q[issp_pkg::WORD_W-2:0], 1'b0};        // RULE_02
          end
          if (sclk_rise) begin
            rx_d  = rx_word;                                    // RULE_04
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == issp_pkg::CNT_W'(issp_pkg::LAST_BIT)) begin
              state_d = issp_pkg::ISSP_HOLD;                    // RULE_02
              if (rx_word[issp_pkg::RW_POS]) begin
                wr_valid_d = 1'b1;                              // RULE_10
                wr_addr_d  = rx_word[issp_pkg::ADDR_MSB:issp_pkg::ADDR_LSB];
                wr_data_d  = rx_word[issp_pkg::BYTE_W-1:0];
                reg_we     = 1'b1;
              end else begin
                tx_d = regs_q[rx_word[issp_pkg::ADDR_MSB:issp_pkg::IDX_LSB]]; // RULE_09
              end
            end
          end
        end
      end
      issp_pkg::ISSP_HOLD: begin
        // clocks past the sixteenth are ignored until select rises
        if (!cs_act) begin
          state_d = issp_pkg::ISSP_IDLE;                        // RULE_13
          cnt_d   = '0;
        end
      end
      default: begin
        state_d = issp_pkg::ISSP_IDLE;
        cnt_d   = '0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= issp_pkg::ISSP_IDLE;
      cnt_q      <= '0;
      rx_q       <= issp_pkg::WORD_RST;
      sh_q       <= issp_pkg::WORD_RST;
      tx_q       <= issp_pkg::WORD_RST;
      miso_q     <= 1'b0;
      oe_q       <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_addr_q  <= issp_pkg::ADDR_RST;
      wr_data_q  <= issp_pkg::BYTE_RST;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      rx_q       <= rx_d;
      sh_q       <= sh_d;
      tx_q       <= tx_d;
      miso_q     <= miso_d;
      oe_q       <= oe_d;
      wr_valid_q <= wr_valid_d;
      wr_addr_q  <= wr_addr_d;
      wr_data_q  <= wr_data_d;
    end
  end

  assign miso_o       = miso_q;
  assign miso_oe      = oe_q;
  assign cfg_wr_valid = wr_valid_q;
  assign cfg_wr_addr  = wr_addr_q;
  assign cfg_wr_data  = wr_data_q;

  // ****************************************
  // output registers and data ready
  // ****************************************
  // results drain only between frames, so a word never changes mid-read;
  // a long select makes the buffer fill and stalls the sensor stream
  assign fifo_pop = fifo_valid && !cs_act && (state_q == issp_pkg::ISSP_IDLE); // RULE_07

  logic [issp_pkg::DR_CNT_W-1:0] dr_cnt_q, dr_cnt_d;
  logic                          dr_q, dr_d;

  always_comb begin
    dr_cnt_d = dr_cnt_q;
    if (fifo_pop && pop_last) begin
      dr_cnt_d = issp_pkg::DR_CNT_W'(issp_pkg::DR_PULSE_CYC);   // RULE_06
    end else if (dr_cnt_q != '0) begin
      dr_cnt_d = dr_cnt_q - 1'b1;
    end
    dr_d = (dr_cnt_d != '0);                                    // RULE_06
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dr_cnt_q             <= '0;
      dr_q                 <= 1'b0;
      config_io_pin_two_oe <= 1'b0;
    end else begin
      dr_cnt_q             <= dr_cnt_d;
      dr_q                 <= dr_d;
      config_io_pin_two_oe <= 1'b1;
    end
  end

  assign config_io_pin_two_o = dr_q;

  // byte writes and result loads never meet: loads wait for an idle select
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= issp_pkg::WORD_RST;
      end
    end else if (fifo_pop) begin
      regs_q[pop_idx] <= pop_word;                              // RULE_07
    end else if (reg_we) begin
      if (wr_addr_d[0]) begin
        regs_q[wr_addr_d[issp_pkg::ADDR_W-1:1]][issp_pkg::WORD_W-1:issp_pkg::BYTE_W] <= wr_data_d;
      end else begin
        regs_q[wr_addr_d[issp_pkg::ADDR_W-1:1]][issp_pkg::BYTE_W-1:0] <= wr_data_d; // RULE_10
      end
    end
  end

endmodule

`default_nettype wire

// [dv/issp_monitor.sv]
// Concurrent checks on the pins of the serial slave port.
// Assumes one clk domain; reset is synchronous and active high.
`timescale 1ns/1ps
`default_nettype none
module issp_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  // side outputs
  input wire logic cfg_wr_valid,
  input wire logic config_io_pin_two_o,
  input wire logic config_io_pin_two_oe
);
  localparam logic [7:0] PULSE_LEN = 8'(issp_pkg::DR_PULSE_CYC);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************
  // data-ready run length
  // ****************************************
  logic [7:0] run_q;
  logic [7:0] run_d;
  always_comb begin
    run_d = config_io_pin_two_o ? run_q + 8'h01 : 8'h00;
  end
  always_ff @(posedge clk) begin
    run_q <= reset ? 8'h00 : run_d;
  end
  // select seen low for two samples, so a glitch does not count
  sequence s_sel_fall;
    $fell(cs_n) ##1 !cs_n;
  endsequence
  // a serial clock fall landed three to six samples back
  sequence s_bit_fall;
    $past(sclk, 6) && !$past(sclk, 3);
  endsequence
  // a serial clock rise landed two to six samples back
  sequence s_bit_rise;
    $past(sclk, 2) && !$past(sclk, 6);
  endsequence
  a_select_opens_drive: assert property (s_sel_fall |-> ##[1:3] miso_oe)
    else $error("output drive late after select");
  a_drive_tracks_sel: assert property (!$past(reset, 4) |-> miso_oe == !$past(cs_n, 3))
    else $error("output drive does not follow select");
  a_quiet_released: assert property (cs_n [*5] |-> !miso_oe)
    else $error("output driven while deselected");
  a_out_on_fall: assert property ($changed(miso_o) && $past(miso_oe) |-> s_bit_fall)
    else $error("serial output moved without a clock fall");
  a_write_after_rise: assert property ($rose(cfg_wr_valid) |-> s_bit_rise)
    else $error("write strobe not tied to a clock rise");
  a_write_one_cycle: assert property (cfg_wr_valid |=> !cfg_wr_valid)
    else $error("write strobe longer than a cycle");
  a_write_in_frame: assert property (cfg_wr_valid |-> !$past(cs_n, 5))
    else $error("write strobe outside a selected frame");
  a_ready_width: assert property ($fell(config_io_pin_two_o) |-> run_q == PULSE_LEN)
    else $error("data-ready pulse width wrong");
  a_pin_enabled: assert property (!$past(reset) |-> config_io_pin_two_oe)
    else $error("data-ready pin not driven");
endmodule
bind issp_port issp_monitor u_mon (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n),
  .miso_o(miso_o), .miso_oe(miso_oe), .cfg_wr_valid(cfg_wr_valid),
  .config_io_pin_two_o(config_io_pin_two_o), .config_io_pin_two_oe(config_io_pin_two_oe));
`default_nettype wire

// [dv/issp_master.sv]
// Behavioural serial master that drives frames into the port.
// Assumes clk is the port's system clock; pins move on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module issp_master (
  // pacing clock
  input wire logic clk,
  // serial link
  output logic     sclk,
  output logic     cs_n,
  output logic     mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  localparam int HALF  = 4;  // 400 ns link clock, far under 15 MHz
  localparam int STALL = 40; // 2 us idle after each frame
  wire logic miso_line = miso_oe ? miso_o : 1'bz;
  initial begin
    sclk = 1'b1; // master alone makes clock and select; clock idles high
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic pace(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic select(input logic v);
    @(negedge clk);
    cs_n = v; // one select per frame
    if (v) pace(STALL);
  endtask
  // nbits below 16 aborts the frame early
  task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
    rx = 16'h0000;
    select(1'b0);
    pace(HALF);
    for (int i = 15; i > 15 - nbits; i--) begin // msb first, nbits bits from bit 15
      sclk = 1'b0;
      mosi = tx[i];
      pace(HALF);
      sclk = 1'b1;
      rx[i] = miso_line;
      pace(HALF);
    end
    // no pull on the data line, so a stale bit must not look valid
    mosi = ~mosi;
    select(1'b1);
  endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the serial slave port with a master model.
// Assumes the port, its FIFO and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
  begin compares++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top;
  logic        clk, reset, sclk, cs_n, mosi, miso_o, miso_oe, pin_o, pin_oe;
  logic        sample_valid, sample_last, sample_ready, cfg_wr_valid;
  logic [5:0]  sample_index;
  logic [15:0] sample_data, rx;
  logic [6:0]  cfg_wr_addr, wr_addr;
  logic [7:0]  cfg_wr_data, wr_data;
  int          fail_count = 0;
  int          compares = 0;
  int          wr_n = 0;
  initial clk = 1'b0;
  always #25 clk = ~clk;
  issp_port u_dut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso_o(miso_o), .miso_oe(miso_oe), .sample_valid(sample_valid),
    .sample_index(sample_index), .sample_data(sample_data), .sample_last(sample_last),
    .sample_ready(sample_ready), .cfg_wr_valid(cfg_wr_valid), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data), .config_io_pin_two_o(pin_o), .config_io_pin_two_oe(pin_oe));
  issp_master u_m (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe));
  always @(negedge clk) if (cfg_wr_valid === 1'b1) begin
    wr_n++;
    wr_addr = cfg_wr_addr;
    wr_data = cfg_wr_data;
  end
  task automatic push(input logic [5:0] idx, input logic [15:0] d, input logic lst);
    int n;
    n = 0;
    @(negedge clk);
    sample_valid = 1'b1;
    sample_index = idx;
    sample_data = d;
    sample_last = lst;
    // ready seen here is what the next rising edge samples
    while (sample_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) fail_count++;
    @(negedge clk);
    sample_valid = 1'b0;
  endtask
  task automatic expect_pulse();
    int n;
    int w;
    n = 0;
    w = 1;
    do begin @(negedge clk); n++; end while (pin_o !== 1'b1 && n < 100);
    do begin @(negedge clk); w++; end while (pin_o === 1'b1 && w < 100);
    `CHK(w - 1, issp_pkg::DR_PULSE_CYC)
  endtask
  task automatic t_reset();
    repeat (6) @(negedge clk);
    `CHK(miso_oe, 1'b0)
    `CHK(pin_oe, 1'b0)
    repeat (6) @(negedge clk);
    reset = 1'b0; // held inactive from here on
    repeat (3) @(negedge clk);
    `CHK(pin_oe, 1'b1)
    `CHK(sample_ready, 1'b1)
  endtask
  task automatic t_load_read();
    push(6'h0D, 16'hBEEF, 1'b1);
    expect_pulse();
    u_m.xfer(16'h1A00, 16, rx);
    u_m.xfer(16'h1800, 16, rx);
    `CHK(rx, 16'hBEEF)
    u_m.xfer(16'h0000, 16, rx);
    `CHK(rx, 16'h0000)
  endtask
  task automatic t_write();
    u_m.xfer(16'h8003, 16, rx);
    `CHK(wr_n, 1)
    `CHK({wr_addr, wr_data}, {7'h00, 8'h03})
    u_m.xfer(16'h9B12, 16, rx);
    u_m.xfer(16'h1A00, 16, rx);
    `CHK(rx, 16'h0000)
    u_m.xfer(16'h0000, 16, rx);
    `CHK(rx, 16'h12EF)
  endtask
  task automatic t_abort();
    u_m.xfer(16'h1A00, 8, rx);
    u_m.xfer(16'h0000, 16, rx);
    `CHK(rx, 16'h0000)
    u_m.xfer(16'h80FF, 8, rx);
    `CHK(wr_n, 2)
    u_m.xfer(16'h8155, 16, rx);
    `CHK({wr_addr, wr_data}, {7'h01, 8'h55})
  endtask
  // held select blocks draining, so the buffer must fill and refuse
  task automatic t_fill();
    u_m.select(1'b0);
    for (int k = 0; k < 32; k++) push(6'(k), {10'h004, 6'(k)}, k == 31);
    repeat (3) @(negedge clk);
    `CHK(sample_ready, 1'b0)
    // pulse starts while the stall is still running, so watch it alongside
    fork
      u_m.select(1'b1);
      expect_pulse();
    join
    `CHK(sample_ready, 1'b1)
    u_m.xfer(16'h3E00, 16, rx);
    u_m.xfer(16'h0000, 16, rx);
    `CHK(rx, 16'h011F)
  endtask
  task automatic close_out();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    reset = 1'b1;
    sample_valid = 1'b0;
    sample_index = 6'h00;
    sample_data = 16'h0000;
    sample_last = 1'b0;
    t_reset();
    t_load_read();
    t_write();
    t_abort();
    t_fill();
    close_out();
  end
  // tests need about 2300 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end
endmodule
`default_nettype wire
